// ==== logic/twm_pkg.sv ====
// Shared constants for the two-wire master sequencer
package twm_pkg;
  // System clock period and bus quarter-bit time
  localparam int CLK_NS = 10;
  localparam int QTR_NS = 2500;
  // Least time, so round up to whole cycles
  localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;

  // Register port
  localparam int ADDR_W = 2;
  localparam logic [1:0] ADR_CTRL = 2'h0;
  localparam logic [1:0] ADR_STAT = 2'h1;
  localparam logic [1:0] ADR_DATA = 2'h2;

  // Control register bit positions, and the read/write bit of the address byte
  localparam int B_DONE = 7;
  localparam int B_ACK = 6;
  localparam int B_BEGIN = 5;
  localparam int B_HALT = 4;
  localparam int B_WCOL = 3;
  localparam int B_EN = 2;
  localparam int B_RSV = 1;
  localparam int B_IRQ = 0;
  localparam int B_RW = 0;

  // Reset values, and the last bit index of a byte
  localparam logic [7:0] DATA_RST = 8'hff;
  localparam logic [2:0] BIT_TOP = 3'h7;
  localparam logic [2:0] BIT_LAST = 3'h0;

  // Status codes, low three bits always read as zero
  localparam logic [7:0] ST_START = 8'h08;
  localparam logic [7:0] ST_RSTART = 8'h10;
  localparam logic [7:0] ST_AW_ACK = 8'h18;
  localparam logic [7:0] ST_AW_NACK = 8'h20;
  localparam logic [7:0] ST_DT_ACK = 8'h28;
  localparam logic [7:0] ST_DT_NACK = 8'h30;
  localparam logic [7:0] ST_ARB = 8'h38;
  localparam logic [7:0] ST_AR_ACK = 8'h40;
  localparam logic [7:0] ST_AR_NACK = 8'h48;
  localparam logic [7:0] ST_DR_ACK = 8'h50;
  localparam logic [7:0] ST_DR_NACK = 8'h58;
  localparam logic [7:0] ST_NONE = 8'hf8;

  // Bit engine commands
  typedef enum logic [1:0] {
    BC_START = 2'b00,
    BC_STOP = 2'b01,
    BC_WBIT = 2'b10,
    BC_RBIT = 2'b11
  } twm_bcmd_e;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam logic [1:0] PH_END = 2'h3;
endpackage

// ==== logic/twm_bit_engine.sv ====
// Bit-level engine: START, STOP and single data bits on the wires
`timescale 1ns/1ps
module twm_bit_engine #(
  parameter int QTR = twm_pkg::QTR_CYC
) (
  input wire logic clk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic abort, // Release both lines now
  input wire logic go, // Start one command
  input wire twm_pkg::twm_bcmd_e cmd, // Command kind
  input wire logic wbit, // Bit to send
  input wire logic scl_s, // Synchronised clock line
  input wire logic sda_s, // Synchronised data line
  output logic done, // Command finished pulse
  output logic rbit, // Sampled data bit
  output logic lost, // Arbitration lost in last bit
  output logic scl_lvl, // Wanted clock line level
  output logic sda_lvl // Wanted data line level
);
  import twm_pkg::*;
  localparam int CW = $clog2(QTR + 1);

  logic active;
  twm_bcmd_e cmd_r;
  logic wbit_r;
  logic [1:0] ph;
  logic [CW-1:0] cnt;

  // Line levels for each phase of each command
  function automatic logic [1:0] lv(twm_bcmd_e c, logic [1:0] p,
                                    logic b, logic scl_now);
    logic [1:0] r;
    r = 2'h3;
    case (c)
      BC_START: r = (p == 2'h0) ? {scl_now, 1'b1} :
                    (p == 2'h1) ? 2'h3 : (p == 2'h2) ? 2'h2 : 2'h0;
      BC_STOP: r = (p == 2'h0) ? 2'h0 : (p == 2'h1) ? 2'h2 : 2'h3;
      default: r = {(p == 2'h1) || (p == 2'h2), b};
    endcase
    return r;
  endfunction

  // A slave holding the clock low stretches the phase
  wire stretch = scl_lvl && !scl_s;
  wire step = active && !stretch && (cnt == CW'(QTR - 1));
  wire [1:0] next_ph = ph + 2'h1;
  wire [1:0] go_lv = lv(cmd, 2'h0, wbit, scl_lvl);
  wire [1:0] step_lv = lv(cmd_r, next_ph, wbit_r, scl_lvl);

  // Phase timer and line drive
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      active <= 1'b0;
      cmd_r <= BC_START;
      wbit_r <= 1'b1;
      ph <= 2'h0;
      cnt <= '0;
      {scl_lvl, sda_lvl} <= 2'h3;
      done <= 1'b0;
      rbit <= 1'b1;
      lost <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        active <= 1'b0;
        {scl_lvl, sda_lvl} <= 2'h3;
      end else if (go && !active) begin
        active <= 1'b1;
        cmd_r <= cmd;
        wbit_r <= wbit;
        ph <= 2'h0;
        cnt <= '0;
        lost <= 1'b0;
        {scl_lvl, sda_lvl} <= go_lv;
      end else if (step) begin
        cnt <= '0;
        if (ph == PH_END) begin
          active <= 1'b0;
          done <= 1'b1;
        end else begin
          ph <= next_ph;
          {scl_lvl, sda_lvl} <= step_lv;
        end
        // Sent a one but the line reads zero: another master won
        if (ph == PH_SAMPLE) begin
          rbit <= sda_s;
          lost <= (cmd_r == BC_WBIT) && wbit_r && !sda_s;
        end
      end else if (active && !stretch) begin
        cnt <= cnt + CW'(1);
      end
    end
  end
endmodule

// ==== logic/twm_seq.sv ====
// Master transmit and receive sequencer with its register port
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
module twm_seq (
  input wire logic clk, // System clock, 100 MHz
  input wire logic resetn, // Async reset, active low
  input wire logic [twm_pkg::ADDR_W-1:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after rd
  input wire logic scl_in, // Clock line level
  output logic scl_out, // Clock line drive value
  output logic scl_oe, // Clock line pulled low
  input wire logic sda_in, // Data line level
  output logic sda_out, // Data line drive value
  output logic sda_oe // Data line pulled low
);
  import twm_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_WFREE = 4'h1,
    S_START = 4'h2,
    S_HOLD = 4'h3,
    S_TXBIT = 4'h4,
    S_TXACK = 4'h5,
    S_RXBIT = 4'h6,
    S_RXACK = 4'h7,
    S_STOP = 4'h8
  } twm_state_e;

  // Pick one of two codes by an acknowledge bit
  function automatic logic [7:0] pick(logic ack, logic [7:0] a,
                                      logic [7:0] n);
    return ack ? a : n;
  endfunction

  // Control, status and data registers
  logic op_done, ack_en, begin_req, halt_req, wcol, en, irq_en;
  logic [7:0] code;
  logic [7:0] data;
  twm_state_e state;
  logic [2:0] bitn;
  logic is_addr, is_read, master, ack_plan;

  // Line synchronisers and bus watch
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d, bus_busy;

  // Engine handshake
  logic eng_done, eng_rbit, eng_lost, scl_lvl, sda_lvl;

  // Next-state values from the sequencer
  twm_state_e next_state;
  logic [7:0] next_code;
  logic [2:0] next_bitn;
  logic next_addr, next_read, next_master;
  logic set_flag, clr_halt, shift_in, latch_ack, eng_go, eng_bit;
  twm_bcmd_e eng_cmd;

  // Register port decode
  wire wr_ctrl = wr && (addr == ADR_CTRL);
  wire wr_data = wr && (addr == ADR_DATA);
  wire held = (state == S_HOLD) && !op_done;
  wire ack_seen = !eng_rbit;
  wire [2:0] nbit = bitn - 3'h1;
  wire abort = !en || ((state == S_TXBIT) && eng_done && eng_lost);
  wire is_sent_addr = (code == ST_START) || (code == ST_RSTART);
  wire is_tx_code = (code == ST_AW_ACK) || (code == ST_AW_NACK) ||
                    (code == ST_DT_ACK) || (code == ST_DT_NACK);
  wire is_rx_code = (code == ST_AR_ACK) || (code == ST_DR_ACK);
  wire start_seen = scl_s && scl_d && sda_d && !sda_s;
  wire stop_seen = scl_s && scl_d && !sda_d && sda_s;

  // Two flops before any logic reads the pins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
    end
  end

  // Bus is busy from any START seen until a STOP
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_busy <= 1'b0;
    end else if (start_seen) begin
      bus_busy <= 1'b1;
    end else if (stop_seen) begin
      bus_busy <= 1'b0;
    end
  end

  twm_bit_engine #(.QTR(QTR_CYC)) u_eng (
    .clk(clk),
    .resetn(resetn),
    .abort(abort),
    .go(eng_go),
    .cmd(eng_cmd),
    .wbit(eng_bit),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .done(eng_done),
    .rbit(eng_rbit),
    .lost(eng_lost),
    .scl_lvl(scl_lvl),
    .sda_lvl(sda_lvl)
  );

  // Byte sequencing; apart from the disable, all moves but those from S_IDLE, S_WFREE and S_HOLD wait on engine completion
  always_comb begin
    next_state = state;
    next_code = code;
    next_bitn = bitn;
    next_addr = is_addr;
    next_read = is_read;
    next_master = master;
    set_flag = 1'b0;
    clr_halt = 1'b0;
    shift_in = 1'b0;
    latch_ack = 1'b0;
    eng_go = 1'b0;
    eng_cmd = BC_START;
    eng_bit = 1'b1;
    case (state)
      S_IDLE: begin
        if (en && begin_req && !op_done) begin
          next_state = S_WFREE;
        end
      end
      S_WFREE: begin
        if (!bus_busy) begin
          eng_go = 1'b1;
          next_state = S_START;
        end
      end
      S_START: begin
        if (eng_done) begin
          set_flag = 1'b1;
          next_code = pick(master, ST_RSTART, ST_START);
          next_master = 1'b1;
          next_state = S_HOLD;
        end
      end
      S_HOLD: begin
        // Nothing moves on the bus until the flag is cleared
        if (held) begin
          latch_ack = 1'b1;
          if (halt_req && master) begin
            eng_go = 1'b1;
            eng_cmd = BC_STOP;
            next_state = S_STOP;
          end else if (halt_req) begin
            clr_halt = 1'b1;
            next_state = S_IDLE;
          end else if (begin_req && master) begin
            eng_go = 1'b1;
            next_state = S_START;
          end else if (begin_req) begin
            next_state = S_WFREE;
          end else if (!master) begin
            next_state = S_IDLE;
          end else if (is_sent_addr || is_tx_code) begin
            next_addr = is_sent_addr;
            if (is_sent_addr) begin
              next_read = data[B_RW];
            end
            next_bitn = BIT_TOP;
            eng_go = 1'b1;
            eng_cmd = BC_WBIT;
            eng_bit = data[BIT_TOP];
            next_state = S_TXBIT;
          end else if (is_rx_code) begin
            next_bitn = BIT_TOP;
            eng_go = 1'b1;
            eng_cmd = BC_RBIT;
            next_state = S_RXBIT;
          end
        end
      end
      S_TXBIT: begin
        if (eng_done && eng_lost) begin
          set_flag = 1'b1;
          next_code = ST_ARB;
          next_master = 1'b0;
          next_state = S_HOLD;
        end else if (eng_done) begin
          eng_go = 1'b1;
          if (bitn == BIT_LAST) begin
            eng_cmd = BC_RBIT;
            next_state = S_TXACK;
          end else begin
            eng_cmd = BC_WBIT;
            eng_bit = data[nbit];
            next_bitn = nbit;
          end
        end
      end
      S_TXACK: begin
        if (eng_done) begin
          set_flag = 1'b1;
          next_state = S_HOLD;
          if (!is_addr) begin
            next_code = pick(ack_seen, ST_DT_ACK, ST_DT_NACK);
          end else if (is_read) begin
            next_code = pick(ack_seen, ST_AR_ACK, ST_AR_NACK);
          end else begin
            next_code = pick(ack_seen, ST_AW_ACK, ST_AW_NACK);
          end
        end
      end
      S_RXBIT: begin
        if (eng_done) begin
          shift_in = 1'b1;
          eng_go = 1'b1;
          if (bitn == BIT_LAST) begin
            eng_cmd = BC_WBIT;
            eng_bit = !ack_plan;
            next_state = S_RXACK;
          end else begin
            eng_cmd = BC_RBIT;
            next_bitn = nbit;
          end
        end
      end
      S_RXACK: begin
        if (eng_done) begin
          set_flag = 1'b1;
          next_code = pick(ack_plan, ST_DR_ACK, ST_DR_NACK);
          next_state = S_HOLD;
        end
      end
      S_STOP: begin
        if (eng_done) begin
          clr_halt = 1'b1;
          next_master = 1'b0;
          next_code = ST_NONE;
          next_state = begin_req ? S_WFREE : S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
    // Disabling returns to S_IDLE, drops mastership and releases the lines; flag and status code keep their values
    if (!en) begin
      next_state = S_IDLE;
      next_master = 1'b0;
    end
  end

  // Sequencer state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= S_IDLE;
      code <= ST_NONE;
      bitn <= BIT_TOP;
      {is_addr, is_read, master, ack_plan} <= 4'h0;
    end else begin
      state <= next_state;
      code <= next_code;
      bitn <= next_bitn;
      {is_addr, is_read, master} <= {next_addr, next_read, next_master};
      if (latch_ack) begin
        ack_plan <= ack_en;
      end
    end
  end

  // Completion flag: a hardware set beats a software clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      op_done <= 1'b0;
    end else if (set_flag) begin
      op_done <= 1'b1;
    end else if (wr_ctrl && wdata[B_DONE]) begin
      op_done <= 1'b0;
    end
  end

  // Software control bits; halt also clears itself after STOP
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {ack_en, begin_req, halt_req, en, irq_en} <= 5'h00;
    end else if (wr_ctrl) begin
      ack_en <= wdata[B_ACK];
      begin_req <= wdata[B_BEGIN];
      halt_req <= wdata[B_HALT];
      en <= wdata[B_EN];
      irq_en <= wdata[B_IRQ];
    end else if (clr_halt) begin
      halt_req <= 1'b0;
    end
  end

  // Data register: software loads only while the flag is up
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data <= DATA_RST;
      wcol <= 1'b0;
    end else if (wr_data && !op_done) begin
      wcol <= 1'b1;
    end else if (wr_data) begin
      data <= wdata;
      wcol <= 1'b0;
    end else if (shift_in) begin
      data <= {data[6:0], eng_rbit};
    end
  end

  // Read mux; reserved control bit reads zero
  wire [7:0] ctrl_rd;
  assign ctrl_rd[B_DONE] = op_done;
  assign ctrl_rd[B_ACK] = ack_en;
  assign ctrl_rd[B_BEGIN] = begin_req;
  assign ctrl_rd[B_HALT] = halt_req;
  assign ctrl_rd[B_WCOL] = wcol;
  assign ctrl_rd[B_EN] = en;
  assign ctrl_rd[B_RSV] = 1'b0;
  assign ctrl_rd[B_IRQ] = irq_en;
  wire [7:0] rd_val = (addr == ADR_CTRL) ? ctrl_rd :
                      (addr == ADR_STAT) ? code :
                      (addr == ADR_DATA) ? data : 8'h00;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? rd_val : 8'h00;
    end
  end

  // Open-drain: only ever pull low, enable when level is low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = !scl_lvl;
  assign sda_oe = !sda_lvl;
endmodule

// ==== tb/twm_seq_properties.sv ====
// Port properties of the two-wire master sequencer
`timescale 1ns/1ps
module twm_seq_properties (
  input wire logic clk, // Clock
  input wire logic resetn, // Reset, active low
  input wire logic [twm_pkg::ADDR_W-1:0] addr, // Address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic [7:0] rdata, // Read data
  input wire logic scl_in, // Clock line
  input wire logic scl_out, // Clock drive
  input wire logic scl_oe, // Clock pull low
  input wire logic sda_in, // Data line
  input wire logic sda_out, // Data drive
  input wire logic sda_oe // Data pull low
);
  import twm_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Register port answers
  a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data outside its slot");
  a_status_low: assert property (rd && addr == ADR_STAT |=>
    rdata[2:0] == 3'h0) else $error("status low bits set");
  a_unmapped_zero: assert property (rd && addr == 2'h3 |=>
    rdata == 8'h00) else $error("unmapped read not zero");
  a_ctrl_rsv: assert property (rd && addr == ADR_CTRL |=>
    !rdata[B_RSV]) else $error("reserved control bit set");
  // Lines are only ever pulled low, and free after reset
  a_open_drain: assert property (!scl_out && !sda_out)
    else $error("line driven high");
  a_reset_free: assert property ($rose(resetn) |->
    !scl_oe && !sda_oe) else $error("line held after reset");
  // Data falls with clock high only as a START, clock then follows
  a_start_shape: assert property ($rose(sda_oe) && !scl_oe |=>
    !scl_oe [*8] ##[200:300] scl_oe) else $error("bad start shape");
  // Data rises with clock high only as a STOP, both stay free
  a_stop_shape: assert property ($fell(sda_oe) && !scl_oe |=>
    (!sda_oe && !scl_oe) [*8]) else $error("bad stop shape");
  // Clock phases are never glitches
  a_scl_high: assert property ($fell(scl_oe) |=> !scl_oe [*8])
    else $error("short clock high");
  a_scl_low: assert property ($rose(scl_oe) |=> scl_oe [*8])
    else $error("short clock low");
  c_start: cover property ($rose(sda_oe) && !scl_oe);
  c_stop: cover property ($fell(sda_oe) && !scl_oe);
  c_data_rd: cover property (rd && addr == ADR_DATA);
endmodule

bind twm_seq twm_seq_properties u_props (
  .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe)
);

// ==== tb/twm_slave_model.sv ====
// Behavioural slave device on the two-wire bus
`timescale 1ns/1ps
module twm_slave_model #(
  parameter logic [6:0] SADDR = 7'h2a // Own address
) (
  input wire logic scl, // Clock line level
  input wire logic sda, // Data line level
  input wire logic nack_req, // Refuse written bytes
  input wire logic [7:0] tx_byte, // Next byte to send
  output logic sda_low, // Pull data line low
  output logic [7:0] rx_byte, // Last byte written
  output logic mack // Master acked last bit nine
);
  logic [3:0] cnt = 4'h0;
  logic [7:0] sh = 8'h00;
  logic first = 1'b0;
  logic sel = 1'b0;
  logic rdm = 1'b0;
  initial begin
    sda_low = 1'b0;
    rx_byte = 8'h00;
    mack = 1'b0;
  end
  // START restarts framing; STOP deselects
  always @(negedge sda) if (scl) begin
    cnt = 4'h0;
    first = 1'b1;
    rdm = 1'b0;
  end
  always @(posedge sda) if (scl) begin
    sel = 1'b0;
    rdm = 1'b0;
  end
  // Sample on the rising clock; bits arrive most significant first
  always @(posedge scl) begin
    if (cnt < 4'h8 && !rdm) sh = {sh[6:0], sda};
    if (cnt == 4'h8) mack = !sda;
    cnt = cnt + 4'h1;
  end
  // Change the data line only while the clock is low
  always @(negedge scl) begin
    if (cnt == 4'h8) begin
      if (first) begin
        sel = (sh[7:1] == SADDR);
        rdm = sel && sh[0];
      end else if (!rdm) rx_byte = sh;
      sda_low = sel && (first || (!rdm && !nack_req));
      first = 1'b0;
    end else if (cnt == 4'h9) begin
      cnt = 4'h0;
      // A not-acknowledge ends our sending, so the bus is freed
      rdm = rdm && mack;
      sh = tx_byte;
      sda_low = rdm && !sh[7];
    end else if (rdm && !first && cnt != 4'h0) begin
      sda_low = !sh[3'h7 - cnt[2:0]];
    end
  end
endmodule

// ==== tb/tb_twm_seq.sv ====
// Self-checking bench for the two-wire master sequencer
`timescale 1ns/1ps
module tb_twm_seq;
  import twm_pkg::*;
  localparam logic [6:0] SADDR = 7'h2a;
  logic clk, resetn, wr, rd, ck, rd_d, ck_d, nack_req, sda_low, mack;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, tx_byte, rx_byte, v, b;
  logic [7:0] rb [2];
  logic scl_oe, sda_oe, scl_w, sda_w;
  int errors, checked;
  logic [7:0] q[$];
  // Pull-ups on both wires; the master may pull either low, the slave only the data wire
  assign scl_w = !scl_oe;
  assign sda_w = !(sda_oe || sda_low);
  twm_seq i_dut (.clk(clk), .resetn(resetn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl_w),
    .scl_out(), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(),
    .sda_oe(sda_oe));
  twm_slave_model #(.SADDR(SADDR)) i_slave (.scl(scl_w), .sda(sda_w),
    .nack_req(nack_req), .tx_byte(tx_byte), .sda_low(sda_low),
    .rx_byte(rx_byte), .mack(mack));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Bus cycles; each leaves a free edge so strobes never double up
  task automatic wrr(input logic [1:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdr(input logic [1:0] a, input logic c,
    input logic [7:0] e, output logic [7:0] r);
    if (c) q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    ck <= c;
    @(posedge clk);
    rd <= 1'b0;
    ck <= 1'b0;
    @(negedge clk);
    r = rdata;
    @(posedge clk);
  endtask
  task automatic ex(input logic [1:0] a, input logic [7:0] e);
    rdr(a, 1'b1, e, v);
  endtask
  // Poll the control register; bounded so a stuck flag shows up
  task automatic wbit(input int idx, input logic val);
    for (int n = 0; n < 8000; n++) begin
      rdr(ADR_CTRL, 1'b0, 8'h00, v);
      if (v[idx] === val) break;
    end
    chk({7'h0, v[idx]}, {7'h0, val});
  endtask
  task automatic go(input logic [7:0] c, input logic [7:0] s);
    wrr(ADR_CTRL, c);
    wbit(B_DONE, 1'b1);
    ex(ADR_STAT, s);
  endtask
  // Read data lands one cycle after the strobe; look mid-cycle, settled
  always @(posedge clk) begin
    rd_d <= rd;
    ck_d <= ck;
  end
  always @(negedge clk) begin
    if (rd_d && ck_d) chk(rdata, q.pop_front());
  end
  // Watchdog sized well past the longest transfer sequence
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    test_done;
  end
  initial begin
    {resetn, wr, rd, ck, rd_d, ck_d, nack_req} = 7'h0;
    {addr, wdata, tx_byte} = 18'h0;
    void'($urandom(32'hf2aa7bf5));
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    // Reset values; unmapped slot ignores writes
    wrr(2'h3, 8'h5a);
    ex(ADR_CTRL, 8'h00);
    ex(ADR_STAT, ST_NONE);
    ex(2'h3, 8'h00);
    $display("test 1 done");
    // Data write with the flag low is thrown away
    wrr(ADR_DATA, 8'h3c);
    ex(ADR_DATA, DATA_RST);
    ex(ADR_CTRL, 8'h08);
    $display("test 2 done");
    // START, then a control write without the flag bit changes nothing
    go(8'ha4, ST_START);
    wrr(ADR_CTRL, 8'h24);
    ex(ADR_CTRL, 8'hac);
    wrr(ADR_DATA, {SADDR, 1'b0});
    ex(ADR_CTRL, 8'ha4);
    go(8'h84, ST_AW_ACK);
    $display("test 3 done");
    // Two data bytes, the second refused by the slave
    for (int i = 0; i < 2; i++) begin
      b = 8'($urandom);
      nack_req <= i[0];
      wrr(ADR_DATA, b);
      go(8'h84, i[0] ? ST_DT_NACK : ST_DT_ACK);
      chk(rx_byte, b);
    end
    nack_req <= 1'b0;
    $display("test 4 done");
    // Repeated START into a read; bus frozen while the flag stands
    rb[0] = 8'($urandom);
    rb[1] = 8'($urandom);
    tx_byte <= rb[0];
    go(8'ha4, ST_RSTART);
    wrr(ADR_DATA, {SADDR, 1'b1});
    go(8'hc4, ST_AR_ACK);
    tx_byte <= rb[1];
    b = {6'h00, scl_oe, sda_oe};
    repeat (600) @(posedge clk);
    chk({6'h00, scl_oe, sda_oe}, b);
    ex(ADR_CTRL, 8'hc4);
    $display("test 5 done");
    // Acked byte, then a last byte answered with not-acknowledge
    for (int i = 0; i < 2; i++) begin
      go(i[0] ? 8'h84 : 8'hc4, i[0] ? ST_DR_NACK : ST_DR_ACK);
      ex(ADR_DATA, rb[i]);
      chk({7'h0, mack}, {7'h0, !i[0]});
    end
    $display("test 6 done");
    // STOP then START; halt clears by itself
    go(8'hb4, ST_START);
    ex(ADR_CTRL, 8'ha4);
    wrr(ADR_DATA, {SADDR ^ 7'h01, 1'b0});
    go(8'h84, ST_AW_NACK);
    wrr(ADR_CTRL, 8'h94);
    wbit(B_HALT, 1'b0);
    ex(ADR_STAT, ST_NONE);
    ex(ADR_CTRL, 8'h04);
    chk({6'h00, scl_oe, sda_oe}, 8'h00);
    $display("test 7 done");
    test_done;
  end
endmodule
